// [afe_ctrl_defines.vh]
// constants for the serial control word interpreter and its register bank
`ifndef AFE_CTRL_DEFINES_VH
`define AFE_CTRL_DEFINES_VH

`define FRAME_W 16
`define CW_CTRL_BIT 15
`define CW_RD_BIT 14
`define CW_DEV_HI 13
`define CW_DEV_LO 11
`define CW_REG_HI 10
`define CW_REG_LO 8
`define CW_DATA_HI 7
`define CW_DATA_LO 0
`define DEV_SELF 3'h0
`define DEV_STEP 3'h1

`define REG_MODE_COUNT 3'h0
`define REG_CLOCK_RATE 3'h1
`define REG_POWER 3'h2
`define REG_GAIN_MUTE 3'h3
`define REG_DAC_ADVANCE 3'h4
`define REG_ANALOG_PATH 3'h5
`define REG_COUNT 6
`define REG_RESET_VAL 8'h00

`define A_OP_MODE 0
`define A_MIXED 1
`define A_DLB 2
`define A_SLB 3
`define A_COUNT_LO 4
`define A_COUNT_HI 6
`define A_SWRESET 7
`define B_RATE_LO 0
`define B_RATE_HI 1
`define B_SCLK_LO 2
`define B_SCLK_HI 3
`define B_MCLK_LO 4
`define B_MCLK_HI 6
`define B_ECHO 7
`define C_GLOBAL_PU 0
`define C_ADC_PU 3
`define C_DAC_PU 4
`define C_REF_PU 5
`define C_REF_OUT 6
`define D_IGAIN_LO 0
`define D_IGAIN_HI 2
`define D_MOD_RST 3
`define D_OGAIN_LO 4
`define D_OGAIN_HI 6
`define D_MUTE 7

`define RATE_DIV_2048 12'h800
`define RATE_DIV_1024 12'h400
`define RATE_DIV_512 12'h200
`define RATE_DIV_256 12'h100
`define MDIV_1 3'h1
`define MDIV_2 3'h2
`define MDIV_3 3'h3
`define MDIV_4 3'h4
`define MDIV_5 3'h5
`define SW_RESET_CYCLES 3'h4

`endif

// [clock_ratio_decode.v]
// decodes the clock and rate control fields into divide ratios
`timescale 1ns/100ps
`default_nettype none
`include "afe_ctrl_defines.vh"
module clock_ratio_decode (
    // codes
    input wire [1:0] rate_code_in,
    input wire [2:0] mclk_code_in,
    // ratios
    output reg [11:0] rate_div_out,
    output reg [2:0] mclk_div_out
);
    always @* begin
        case (rate_code_in)
            2'h0: rate_div_out = `RATE_DIV_2048;
            2'h1: rate_div_out = `RATE_DIV_1024;
            2'h2: rate_div_out = `RATE_DIV_512;
            default: rate_div_out = `RATE_DIV_256;
        endcase
    end

    always @* begin
        case (mclk_code_in)
            3'h1: mclk_div_out = `MDIV_2;
            3'h2: mclk_div_out = `MDIV_3;
            3'h3: mclk_div_out = `MDIV_4;
            3'h4: mclk_div_out = `MDIV_5;
            default: mclk_div_out = `MDIV_1;
        endcase
    end
endmodule // clock_ratio_decode
`default_nettype wire

// [frame_shifter.v]
// 16-bit serial shift register, msb first, with parallel load for output
`timescale 1ns/100ps
`default_nettype none
module frame_shifter #(
    parameter WIDTH = 16
) (
    // clock
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    // control
    input wire shift_in,
    input wire bit_in,
    input wire load_in,
    input wire [WIDTH-1:0] load_word_in,
    // state
    output reg [WIDTH-1:0] word_out
);
    always @(posedge clk_in) begin
        if (rst_in) begin
            word_out <= {WIDTH{1'b0}};
        end else if (ce_in) begin
            if (load_in) begin
                word_out <= load_word_in;
            end else if (shift_in) begin
                word_out <= {word_out[WIDTH-2:0], bit_in};
            end
        end
    end
endmodule // frame_shifter
`default_nettype wire

// [afe_serial_control_word_regs.v]
// control word interpreter and control register bank of the analog front end
// Functional notes
// - bit 15 flags control word; zero means data (data or mixed mode) or invalid (program)
// - read/write bit zero with device address zero writes data field to register
// - read/write bit one loads register into data field and sends word out
// - bits 13..11 are device address; zero means word is ours
// - nonzero device address is decremented and word forwarded on serial output
// - bits 10..8 select register; codes 0..5 valid, 6 and 7 reserved
// - bits 7..0 carry the register value written or read back
// - register A bit 0 picks program mode or data mode
// - register A bits 1..3 enable mixed, digital loopback, serial loopback
// - register A bits 4..6 hold the cascade device count
// - register A bit 7 or reset pin clears registers, four cycles
// - register B bits 1..0 are the sample rate code
// - rate code gives master clock over 2048, 1024, 512 or 256
// - register B bits 3..2 are the serial clock divider code
// - register B bits 6..4 are the master clock divider code
// - master divider codes 0..4 give 1..5, codes 5..7 give one
// - register B bit 7 enables echo of control words on serial output
// - register C bit 0 powers all sections; zero leaves individual enables
// - register C bits 3,4,5 power the adc, dac and reference
// - register C bit 6 enables driving the reference output
// - register D bits 2..0 are the input gain code
// - register D bit 3 holds the adc modulator in reset
// - register D bits 6..4 output gain code; bit 7 mutes output
// - registers update on serial clock falling edge after a write word
`timescale 1ns/100ps
`default_nettype none
`include "afe_ctrl_defines.vh"
module afe_serial_control_word_regs #(
    parameter FRAME_W = `FRAME_W
) (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    // serial link, sampled synchronously
    input wire sclk_in,
    input wire sdi_in,
    input wire sdifs_in,
    output reg sdo_out,
    output reg sdofs_out,
    // mode outputs
    output reg op_mode_select_out,
    output reg mixed_mode_enable_out,
    output reg digital_loopback_enable_out,
    output reg serial_loopback_enable_out,
    output reg [2:0] cascade_count_out,
    output reg in_reset_out,
    // clock settings
    output reg [1:0] rate_code_out,
    output reg [11:0] sample_rate_div_out,
    output reg [1:0] serial_clock_div_out,
    output reg [2:0] master_clock_div_out,
    output reg control_echo_enable_out,
    // power
    output reg adc_power_on_out,
    output reg dac_power_on_out,
    output reg ref_power_on_out,
    output reg reference_output_out,
    // gain
    output reg [2:0] input_gain_out,
    output reg adc_modulator_reset_out,
    output reg [2:0] output_gain_out,
    output reg mute_out,
    // other registers and received data words
    output reg [7:0] dac_advance_reg_out,
    output reg [7:0] analog_path_reg_out,
    output reg [FRAME_W-1:0] data_word_out,
    output reg data_word_valid_out
);
    localparam ST_IDLE = 2'h0;
    localparam ST_RECV = 2'h1;
    localparam ST_SEND = 2'h2;
    localparam CNT_W = 5;

    reg [7:0] regs_r [0:`REG_COUNT-1];
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [CNT_W-1:0] bit_cnt_r;
    reg sclk_d_r;
    reg [2:0] rst_cnt_r;
    reg [FRAME_W-1:0] out_word_r;
    reg out_pend_r;
    reg [CNT_W-1:0] out_cnt_r;

    // named views of the bank, so every field pick says which register it reads
    wire [7:0] mode_and_count_control = regs_r[`REG_MODE_COUNT];
    wire [7:0] clock_and_rate_control = regs_r[`REG_CLOCK_RATE];
    wire [7:0] power_control = regs_r[`REG_POWER];
    wire [7:0] gain_and_mute_control = regs_r[`REG_GAIN_MUTE];
    wire [7:0] dac_advance_control = regs_r[`REG_DAC_ADVANCE];
    wire [7:0] analog_path_control = regs_r[`REG_ANALOG_PATH];

    wire sclk_fall = sclk_d_r & ~sclk_in;
    wire sclk_rise = ~sclk_d_r & sclk_in;
    wire in_soft_reset = (rst_cnt_r != 3'h0);
    wire [FRAME_W-1:0] rx_word;
    wire rx_shift = ce_in & sclk_fall & (state_r == ST_RECV);
    wire [FRAME_W-1:0] rx_full = {rx_word[FRAME_W-2:0], sdi_in};
    wire frame_done = rx_shift && (bit_cnt_r == FRAME_W - 1);

    // fields of the completed word
    wire is_ctrl = rx_full[`CW_CTRL_BIT];
    wire is_read = rx_full[`CW_RD_BIT];
    wire [2:0] dev_addr = rx_full[`CW_DEV_HI:`CW_DEV_LO];
    wire [2:0] reg_addr = rx_full[`CW_REG_HI:`CW_REG_LO];
    wire [7:0] reg_data = rx_full[`CW_DATA_HI:`CW_DATA_LO];
    wire ours = (dev_addr == `DEV_SELF);
    wire reg_ok = (reg_addr < `REG_COUNT);
    // control words are honoured in program mode, or in mixed mode
    wire ctrl_accept = is_ctrl &&
        (~mode_and_count_control[`A_OP_MODE] || mode_and_count_control[`A_MIXED]);
    wire do_write = frame_done && ctrl_accept && ours && ~is_read && reg_ok;
    wire do_read = frame_done && ctrl_accept && ours && is_read;
    wire do_fwd = frame_done && ctrl_accept && ~ours;
    wire do_echo = frame_done && ctrl_accept && ours && ~is_read &&
        clock_and_rate_control[`B_ECHO];
    wire is_data = frame_done && ~is_ctrl && mode_and_count_control[`A_OP_MODE];
    wire [7:0] rd_val = reg_ok ? regs_r[reg_addr] : `REG_RESET_VAL;

    reg [FRAME_W-1:0] tx_word;
    wire [1:0] rate_code = clock_and_rate_control[`B_RATE_HI:`B_RATE_LO];
    wire [2:0] mclk_code = clock_and_rate_control[`B_MCLK_HI:`B_MCLK_LO];
    wire [11:0] rate_div;
    wire [2:0] mclk_div;

    frame_shifter #(
        .WIDTH(FRAME_W)
    ) u_rx (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .shift_in(rx_shift),
        .bit_in(sdi_in),
        .load_in(1'b0),
        .load_word_in({FRAME_W{1'b0}}),
        .word_out(rx_word)
    );

    clock_ratio_decode u_dec (
        .rate_code_in(rate_code),
        .mclk_code_in(mclk_code),
        .rate_div_out(rate_div),
        .mclk_div_out(mclk_div)
    );

    always @* begin
        tx_word = rx_full;
        if (do_read) begin
            tx_word[`CW_DATA_HI:`CW_DATA_LO] = rd_val;
        end else if (do_fwd) begin
            tx_word[`CW_DEV_HI:`CW_DEV_LO] = dev_addr - `DEV_STEP;
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (sdifs_in && sclk_rise && ~in_soft_reset) begin
                    state_nxt = ST_RECV;
                end
            end
            ST_RECV: begin
                if (frame_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // serial clock edges are found against the previous sample
    always @(posedge clk_in) begin
        if (rst_in) begin
            sclk_d_r <= 1'b0;
        end else if (ce_in) begin
            sclk_d_r <= sclk_in;
        end
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            state_r <= ST_IDLE;
        end else if (ce_in) begin
            state_r <= state_nxt;
        end
    end

    // counts the falling edges of the current frame
    always @(posedge clk_in) begin
        if (rst_in) begin
            bit_cnt_r <= {CNT_W{1'b0}};
        end else if (ce_in) begin
            if (state_r != ST_RECV) begin
                bit_cnt_r <= {CNT_W{1'b0}};
            end else if (rx_shift) begin
                bit_cnt_r <= bit_cnt_r + 1'b1;
            end
        end
    end

    // register bank; writes land on the falling serial edge ending the word
    integer i;
    always @(posedge clk_in) begin
        if (rst_in) begin
            for (i = 0; i < `REG_COUNT; i = i + 1) begin
                regs_r[i] <= `REG_RESET_VAL;
            end
        end else if (ce_in) begin
            if (in_soft_reset) begin
                for (i = 0; i < `REG_COUNT; i = i + 1) begin
                    regs_r[i] <= `REG_RESET_VAL;
                end
            end else if (do_write) begin
                regs_r[reg_addr] <= reg_data;
            end
        end
    end

    // soft reset timer; the bank stays cleared and new frames wait while it runs
    always @(posedge clk_in) begin
        if (rst_in) begin
            rst_cnt_r <= 3'h0;
        end else if (ce_in) begin
            if (in_soft_reset) begin
                rst_cnt_r <= rst_cnt_r - 3'h1;
            end else if (do_write && reg_addr == `REG_MODE_COUNT && reg_data[`A_SWRESET]) begin
                rst_cnt_r <= `SW_RESET_CYCLES;
            end
        end
    end

    // serial output: forwarded, read-back or echoed control words
    always @(posedge clk_in) begin
        if (rst_in) begin
            out_word_r <= {FRAME_W{1'b0}};
            out_pend_r <= 1'b0;
            out_cnt_r <= {CNT_W{1'b0}};
            sdo_out <= 1'b0;
            sdofs_out <= 1'b0;
        end else if (ce_in) begin
            if (do_read || do_fwd || do_echo) begin
                out_word_r <= tx_word;
                out_pend_r <= 1'b1;
                out_cnt_r <= {CNT_W{1'b0}};
            end else if (out_pend_r && sclk_rise) begin
                sdofs_out <= (out_cnt_r == {CNT_W{1'b0}});
                sdo_out <= out_word_r[FRAME_W-1];
                out_word_r <= {out_word_r[FRAME_W-2:0], 1'b0};
                if (out_cnt_r == FRAME_W - 1) begin
                    out_pend_r <= 1'b0;
                end
                out_cnt_r <= out_cnt_r + 1'b1;
            end else if (~out_pend_r && sclk_rise) begin
                sdofs_out <= 1'b0;
                sdo_out <= 1'b0;
            end
        end
    end

    // mode settings, registered so they lag the bank by one clock
    always @(posedge clk_in) begin
        if (rst_in) begin
            op_mode_select_out <= 1'b0;
            mixed_mode_enable_out <= 1'b0;
            digital_loopback_enable_out <= 1'b0;
            serial_loopback_enable_out <= 1'b0;
            cascade_count_out <= 3'h0;
            in_reset_out <= 1'b1;
        end else if (ce_in) begin
            op_mode_select_out <= mode_and_count_control[`A_OP_MODE];
            mixed_mode_enable_out <= mode_and_count_control[`A_MIXED];
            digital_loopback_enable_out <= mode_and_count_control[`A_DLB];
            serial_loopback_enable_out <= mode_and_count_control[`A_SLB];
            cascade_count_out <= mode_and_count_control[`A_COUNT_HI:`A_COUNT_LO];
            in_reset_out <= in_soft_reset;
        end
    end

    // clock settings
    always @(posedge clk_in) begin
        if (rst_in) begin
            rate_code_out <= 2'h0;
            sample_rate_div_out <= `RATE_DIV_2048;
            serial_clock_div_out <= 2'h0;
            master_clock_div_out <= `MDIV_1;
            control_echo_enable_out <= 1'b0;
        end else if (ce_in) begin
            rate_code_out <= rate_code;
            sample_rate_div_out <= rate_div;
            serial_clock_div_out <= clock_and_rate_control[`B_SCLK_HI:`B_SCLK_LO];
            master_clock_div_out <= mclk_div;
            control_echo_enable_out <= clock_and_rate_control[`B_ECHO];
        end
    end

    // power settings
    always @(posedge clk_in) begin
        if (rst_in) begin
            adc_power_on_out <= 1'b0;
            dac_power_on_out <= 1'b0;
            ref_power_on_out <= 1'b0;
            reference_output_out <= 1'b0;
        end else if (ce_in) begin
            // global power-up overrides; otherwise each section's own bit
            adc_power_on_out <= power_control[`C_GLOBAL_PU] | power_control[`C_ADC_PU];
            dac_power_on_out <= power_control[`C_GLOBAL_PU] | power_control[`C_DAC_PU];
            ref_power_on_out <= power_control[`C_GLOBAL_PU] | power_control[`C_REF_PU];
            reference_output_out <= power_control[`C_REF_OUT];
        end
    end

    // gain settings, the two raw registers and received data words
    always @(posedge clk_in) begin
        if (rst_in) begin
            input_gain_out <= 3'h0;
            adc_modulator_reset_out <= 1'b0;
            output_gain_out <= 3'h0;
            mute_out <= 1'b0;
            dac_advance_reg_out <= `REG_RESET_VAL;
            analog_path_reg_out <= `REG_RESET_VAL;
            data_word_out <= {FRAME_W{1'b0}};
            data_word_valid_out <= 1'b0;
        end else if (ce_in) begin
            input_gain_out <= gain_and_mute_control[`D_IGAIN_HI:`D_IGAIN_LO];
            adc_modulator_reset_out <= gain_and_mute_control[`D_MOD_RST];
            output_gain_out <= gain_and_mute_control[`D_OGAIN_HI:`D_OGAIN_LO];
            mute_out <= gain_and_mute_control[`D_MUTE];
            dac_advance_reg_out <= dac_advance_control;
            analog_path_reg_out <= analog_path_control;
            data_word_valid_out <= is_data;
            if (is_data) begin
                data_word_out <= rx_full;
            end
        end
    end
endmodule // afe_serial_control_word_regs
`default_nettype wire

// [afe_ctrl_asserts.sv]
// port checker for the control word interpreter
`timescale 1ns/100ps
`default_nettype none
module afe_ctrl_asserts #(
    parameter FRAME_W = 16
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // serial link
    input wire logic sclk_in,
    input wire logic sdo_out,
    input wire logic sdofs_out,
    // settings
    input wire logic in_reset_out,
    input wire logic op_mode_select_out,
    input wire logic mixed_mode_enable_out,
    input wire logic [2:0] cascade_count_out,
    input wire logic [1:0] rate_code_out,
    input wire logic [11:0] sample_rate_div_out,
    input wire logic mute_out,
    input wire logic [7:0] dac_advance_reg_out,
    // data words
    input wire logic [FRAME_W-1:0] data_word_out,
    input wire logic data_word_valid_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    sequence s_soft_hold;
        in_reset_out [*4];
    endsequence
    sequence s_cleared;
        !op_mode_select_out && cascade_count_out == 3'h0 && !mute_out && dac_advance_reg_out == 8'h00;
    endsequence
    a_soft_len: assert property ($rose(in_reset_out) |-> s_soft_hold ##[1:2] !in_reset_out)
        else $error("soft reset length wrong");
    a_soft_clear: assert property ($fell(in_reset_out) |-> ##2 s_cleared)
        else $error("settings not cleared by reset");
    a_rate_map: assert property ($stable(rate_code_out) |-> sample_rate_div_out == (12'h800 >> rate_code_out))
        else $error("sample rate divide wrong");
    a_fs_on_rise: assert property ($rose(sdofs_out) |-> sclk_in)
        else $error("output frame flag off the clock high phase");
    // bound fits the bench serial clock of 13 system clocks
    a_fs_one_bit: assert property ($rose(sdofs_out) |-> ##[1:20] !sdofs_out)
        else $error("output frame flag too long");
    a_sdo_on_rise: assert property ($changed(sdo_out) |-> sclk_in)
        else $error("serial output changed while clock low");
    a_set_on_fall: assert property ($changed(mute_out) |-> !sclk_in)
        else $error("setting changed outside clock low phase");
    a_valid_pulse: assert property (data_word_valid_out |=> !data_word_valid_out)
        else $error("data valid longer than one cycle");
    a_data_flag: assert property (data_word_valid_out |-> !data_word_out[FRAME_W-1] && op_mode_select_out)
        else $error("data word taken outside data modes");
endmodule // afe_ctrl_asserts
`default_nettype wire

// [host_port_model.sv]
// serial host port model: sends one frame and clocks in the reply
`timescale 1ns/100ps
`default_nettype none
module host_port_model #(
    parameter HI = 4,
    parameter LO = 8
) (
    // clock
    input wire logic clk_in,
    // serial link
    input wire logic sdo_in,
    input wire logic sdofs_in,
    output logic sclk_out,
    output logic sdi_out,
    output logic sdifs_out
);
    initial begin
        sclk_out = 0;
        sdi_out = 0;
        sdifs_out = 0;
    end
    // clock stands low between transfers; the second half clocks the reply out
    task automatic xfer(input logic [15:0] w, output logic [15:0] rep, output logic got);
        int i;
        begin
            got = 0;
            for (i = 31; i >= 0; i--) begin
                @(posedge clk_in);
                #1;
                sdifs_out = (i == 31);
                sdi_out = (i > 15) ? w[i-16] : ~sdi_out;
                sclk_out = 1;
                repeat (HI) @(posedge clk_in);
                #1;
                if (i < 16) rep[i] = sdo_in;
                if (i == 15) got = sdofs_in;
                sclk_out = 0;
                repeat (LO) @(posedge clk_in);
            end
        end
    endtask
endmodule // host_port_model
`default_nettype wire

// [tb.sv]
// testbench for the control word interpreter and register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, ob) begin samples_checked++; if ((ob) !== (ex)) begin n_errors++; \
    $display("BAD %s expected %h seen %h", nm, ex, ob); end end
module tb;
    logic clk_in = 0, rst_in = 1, ce_in = 1, sclk_in, sdi_in, sdifs_in, sdo_out, sdofs_out;
    logic op_mode_select_out, mixed_mode_enable_out, digital_loopback_enable_out;
    logic serial_loopback_enable_out, in_reset_out, control_echo_enable_out, adc_power_on_out;
    logic dac_power_on_out, ref_power_on_out, reference_output_out, adc_modulator_reset_out;
    logic mute_out, data_word_valid_out;
    logic [1:0] rate_code_out, serial_clock_div_out;
    logic [2:0] cascade_count_out, master_clock_div_out, input_gain_out, output_gain_out;
    logic [11:0] sample_rate_div_out;
    logic [7:0] dac_advance_reg_out, analog_path_reg_out, v;
    logic [15:0] data_word_out, ed;
    logic [7:0] m [0:7];
    int n_errors = 0, samples_checked = 0, k;
    always #4 clk_in = ~clk_in;
    afe_serial_control_word_regs u_dut (.*);
    host_port_model u_host (.clk_in(clk_in), .sdo_in(sdo_out), .sdofs_in(sdofs_out),
        .sclk_out(sclk_in), .sdi_out(sdi_in), .sdifs_out(sdifs_in));
    task automatic give_verdict;
        begin
            $display("checks %0d mismatches %0d", samples_checked, n_errors);
            if (n_errors == 0 && samples_checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task automatic end_test(input string nm);
        $display("test %s done, mismatches %0d", nm, n_errors);
    endtask
    task automatic do_reset;
        begin
            @(posedge clk_in);
            #1;
            rst_in = 1;
            repeat (2) @(posedge clk_in);
            #1;
            rst_in = 0;
            foreach (m[i]) m[i] = 8'h00;
            ed = 16'h0000;
            repeat (3) @(posedge clk_in);
        end
    endtask
    task automatic check_outs;
        begin
            `CHK("mode", m[0][3:0], {serial_loopback_enable_out, digital_loopback_enable_out,
                mixed_mode_enable_out, op_mode_select_out})
            `CHK("count", m[0][6:4], cascade_count_out)
            `CHK("rate", m[1][1:0], rate_code_out)
            `CHK("ratediv", 12'h800 >> m[1][1:0], sample_rate_div_out)
            `CHK("sclkdiv", m[1][3:2], serial_clock_div_out)
            `CHK("mdiv", (m[1][6:4] < 3'h5) ? m[1][6:4] + 3'h1 : 3'h1, master_clock_div_out)
            `CHK("echo", m[1][7], control_echo_enable_out)
            `CHK("power", {m[2][6], m[2][5:3] | {3{m[2][0]}}}, {reference_output_out,
                ref_power_on_out, dac_power_on_out, adc_power_on_out})
            `CHK("gain", m[3], {mute_out, output_gain_out, adc_modulator_reset_out,
                input_gain_out})
            `CHK("regs", {m[4], m[5]}, {dac_advance_reg_out, analog_path_reg_out})
            `CHK("data", ed, data_word_out)
        end
    endtask
    task automatic cmd(input logic [15:0] w);
        logic [15:0] rep, ex;
        logic got, ev;
        int r;
        begin
            r = w[10:8];
            ev = 0;
            ex = w;
            if (!w[15]) begin
                if (m[0][0]) ed = w;
            end else if (m[0][0] && !m[0][1]) ev = 0; // pure data mode takes no control words
            else if (w[13:11] != 3'h0) begin
                ev = 1;
                ex[13:11] = w[13:11] - 3'h1;
            end else if (w[14]) begin
                ev = 1;
                ex[7:0] = m[r];
            end else begin
                ev = m[1][7];
                if (r < 6) m[r] = w[7:0];
                if (r == 0 && w[7]) foreach (m[i]) m[i] = 8'h00;
            end
            u_host.xfer(w, rep, got);
            // echo on writes that change the echo or reset setting is left unjudged
            if (!(w[15:11] == 5'h10 && r < 2)) `CHK("reply", ev, got)
            if (ev && got) `CHK("word", ex, rep)
            check_outs;
        end
    endtask
    initial begin
        k = $urandom(32'h48d7);
        do_reset;
        check_outs;
        end_test("reset");
        for (k = 0; k < 6; k++) begin
            v = 8'($urandom) & ((k == 0) ? 8'h7e : (k == 1) ? 8'h7f : (k == 2) ? 8'h79 : 8'hff);
            cmd({5'h10, k[2:0], v});
        end
        for (k = 0; k < 8; k++) cmd({8'h81, 1'b0, k[2:0], 2'h0, k[1:0]});
        end_test("write");
        for (k = 0; k < 8; k++) cmd({5'h18, k[2:0], 8'($urandom)});
        cmd(16'h86ff);
        cmd(16'h87ff);
        end_test("read and reserved");
        for (k = 1; k < 8; k++) cmd({1'b1, 1'($urandom), k[2:0], 11'($urandom)});
        cmd(16'h0377);
        end_test("forward");
        cmd(16'h8180);
        cmd(16'h835a);
        cmd(16'hcb00);
        end_test("echo");
        cmd(16'h8003);
        cmd(16'h1234);
        cmd(16'h83a5);
        cmd(16'h8080);
        end_test("mixed and soft reset");
        cmd(16'h8001);
        cmd(16'h0abc);
        cmd(16'h83ff);
        do_reset;
        check_outs;
        end_test("data mode");
        give_verdict;
    end
    initial begin
        // 42 frames of 32 serial bits at 13 clocks each, with ample slack
        repeat (40000) @(posedge clk_in);
        n_errors++;
        give_verdict;
    end
endmodule // tb
bind afe_serial_control_word_regs afe_ctrl_asserts #(.FRAME_W(FRAME_W)) u_chk (.*);
`default_nettype wire
